// ---- hw/csiw_defs.svh ----
// Purpose: Register indices, field positions and reset values
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef CSIW_DEFS_SVH
`define CSIW_DEFS_SVH

`define CSIW_IDX_ACK_MODE    8'h01
`define CSIW_IDX_GEN_CTL     8'h02
`define CSIW_IDX_STATUS      8'h04
`define CSIW_IDX_IRQ_CFG     8'h05
`define CSIW_IDX_WIN_EN      8'h06

`define CSIW_BIT_EXPL_ACK    0
`define CSIW_BIT_RING_EN     0
`define CSIW_BIT_DETECT      3
`define CSIW_BIT_READY       2
`define CSIW_BIT_BATTERY     0
`define CSIW_STEER_HI        7
`define CSIW_STEER_LO        4
`define CSIW_IOWIN_HI        7
`define CSIW_IOWIN_LO        6
`define CSIW_MEMWIN_HI       4

`define CSIW_IRQ_CFG_MASK    8'hfd
`define CSIW_WIN_EN_MASK     8'hdf
`define CSIW_STATUS_MASK     8'h0d
`define CSIW_RST_IRQ_CFG     8'h00
`define CSIW_RST_WIN_EN      8'h00
`define CSIW_RST_GEN_CTL     8'h00
`define CSIW_RST_ACK_MODE    8'h00

`define CSIW_IO_SPACE_LO     16
`define CSIW_MEM_PAGE_LO     12

`endif

// ---- hw/csiw_pkg.sv ----
// Purpose: Types shared by the card interrupt and window enable block
// Assumes: Nothing
// Notes:   Steering codes as seen in the interrupt configuration register
package csiw_pkg;

    typedef enum logic [3:0] {
        CSIW_STEER_NONE  = 4'h0,
        CSIW_STEER_IRQ3  = 4'h3,
        CSIW_STEER_IRQ4  = 4'h4,
        CSIW_STEER_IRQ5  = 4'h5,
        CSIW_STEER_IRQ7  = 4'h7,
        CSIW_STEER_IRQ9  = 4'h9,
        CSIW_STEER_IRQ10 = 4'ha,
        CSIW_STEER_IRQ11 = 4'hb,
        CSIW_STEER_IRQ12 = 4'hc,
        CSIW_STEER_IRQ14 = 4'he,
        CSIW_STEER_IRQ15 = 4'hf
    } csiw_steer_type;

    typedef logic [7:0] csiw_byte_type;

endpackage

// ---- hw/csiw_top.sv ----
// Purpose: Card status interrupt steering and address window enables
// Assumes: APB slave on clk_sys; card pins are asynchronous
// Notes:   Window bounds come from a neighbouring block on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "csiw_defs.svh"

module csiw_top #(
    parameter int ADDR_W      = 26,
    parameter int IO_WINDOWS  = 2,
    parameter int MEM_WINDOWS = 5
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire logic                        card_detect_a_n,
    input  wire logic                        card_detect_b_n,
    input  wire logic                        card_busy_n,
    input  wire logic                        card_status_change_n,
    output logic [15:0]                      irq_out,
    input  wire logic                        sys_valid,
    input  wire logic                        sys_is_io,
    input  wire logic [ADDR_W-1:0]           sys_addr,
    input  wire logic [IO_WINDOWS-1:0][15:0] io_win_start,
    input  wire logic [IO_WINDOWS-1:0][15:0] io_win_stop,
    input  wire logic [MEM_WINDOWS-1:0][7:0] mem_win_start,
    input  wire logic [MEM_WINDOWS-1:0][7:0] mem_win_stop,
    input  wire logic [MEM_WINDOWS-1:0][13:0] mem_win_offset,
    output logic [1:0]                       card_enable_n,
    output logic [ADDR_W-1:0]                card_addr,
    output logic [IO_WINDOWS-1:0]            io_window_hit,
    output logic [MEM_WINDOWS-1:0]           mem_window_hit
);

    // Register layout fixes the window counts and the address span
    if (IO_WINDOWS != 2 || MEM_WINDOWS != 5)
        $error("csiw_top: window counts must be 2 and 5");
    if (ADDR_W < 20 || ADDR_W > 32)
        $error("csiw_top: ADDR_W must be 20 to 32");

    function automatic logic [15:0] steer_decode(input logic [3:0] code);
        logic [15:0] onehot;
        onehot = 16'h0000;
        case (csiw_pkg::csiw_steer_type'(code))
            csiw_pkg::CSIW_STEER_IRQ3:  onehot[3]  = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ4:  onehot[4]  = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ5:  onehot[5]  = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ7:  onehot[7]  = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ9:  onehot[9]  = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ10: onehot[10] = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ11: onehot[11] = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ12: onehot[12] = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ14: onehot[14] = 1'b1;
            csiw_pkg::CSIW_STEER_IRQ15: onehot[15] = 1'b1;
            default:                    onehot     = 16'h0000;
        endcase
        return onehot;
    endfunction

    function automatic logic index_hit(input logic [11:0] addr,
                                       input logic [7:0]  idx);
        return addr == {2'b00, idx, 2'b00};
    endfunction

    csiw_pkg::csiw_byte_type irq_cfg_reg;
    csiw_pkg::csiw_byte_type win_en_reg;
    csiw_pkg::csiw_byte_type gen_ctl_reg;
    csiw_pkg::csiw_byte_type ack_mode_reg;
    logic                    detect_change_flag_reg;
    logic                    ready_change_flag_reg;
    logic                    battery_flag_reg;
    logic [31:0]             prdata_reg;
    logic                    pslverr_reg;
    logic [15:0]             irq_reg;
    logic [1:0]              card_enable_n_reg;
    logic [ADDR_W-1:0]       card_addr_reg;
    logic [IO_WINDOWS-1:0]   io_hit_reg;
    logic [MEM_WINDOWS-1:0]  mem_hit_reg;

    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] prev_reg;

    logic       setup_phase;
    logic       access_done;
    logic       wr_done;
    logic       rd_done;
    logic       mapped;
    logic [7:0] status_view;
    logic       irq_cfg_wr;
    logic       win_en_wr;
    logic       status_wr;
    logic       status_rd;

    logic       card_detect_irq_en;
    logic       ready_irq_en;
    logic       battery_status_irq_en;
    logic       ring_indicate_en;
    logic       explicit_writeback_ack;
    logic [3:0] irq_line_steer;
    logic [1:0] io_window_en;
    logic [4:0] mem_window_en;

    logic detect_event;
    logic ready_event;
    logic battery_event;

    assign irq_line_steer = irq_cfg_reg[`CSIW_STEER_HI:`CSIW_STEER_LO];
    assign card_detect_irq_en    = irq_cfg_reg[`CSIW_BIT_DETECT];
    assign ready_irq_en          = irq_cfg_reg[`CSIW_BIT_READY];
    assign battery_status_irq_en = irq_cfg_reg[`CSIW_BIT_BATTERY];
    assign ring_indicate_en      = gen_ctl_reg[`CSIW_BIT_RING_EN];
    assign explicit_writeback_ack = ack_mode_reg[`CSIW_BIT_EXPL_ACK];
    assign io_window_en  = win_en_reg[`CSIW_IOWIN_HI:`CSIW_IOWIN_LO];
    assign mem_window_en = win_en_reg[`CSIW_MEMWIN_HI:0];

    // APB: read data sampled at setup, answer in the access cycle
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable;
    assign wr_done     = access_done && pwrite && !pslverr_reg;
    assign rd_done     = access_done && !pwrite && !pslverr_reg;
    assign pready      = access_done;
    assign prdata      = prdata_reg;
    assign pslverr     = pslverr_reg;

    assign mapped = index_hit(paddr, `CSIW_IDX_ACK_MODE)
                 || index_hit(paddr, `CSIW_IDX_GEN_CTL)
                 || index_hit(paddr, `CSIW_IDX_STATUS)
                 || index_hit(paddr, `CSIW_IDX_IRQ_CFG)
                 || index_hit(paddr, `CSIW_IDX_WIN_EN);

    assign irq_cfg_wr = wr_done && index_hit(paddr, `CSIW_IDX_IRQ_CFG);
    assign win_en_wr  = wr_done && index_hit(paddr, `CSIW_IDX_WIN_EN);
    assign status_wr  = wr_done && index_hit(paddr, `CSIW_IDX_STATUS);
    assign status_rd  = rd_done && index_hit(paddr, `CSIW_IDX_STATUS);

    assign status_view = {4'h0, detect_change_flag_reg,
                          ready_change_flag_reg, 1'b0,
                          battery_flag_reg};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (setup_phase)
        begin
            pslverr_reg <= !mapped;
            prdata_reg  <= 32'h0000_0000;
            if (!pwrite)
            begin
                if (index_hit(paddr, `CSIW_IDX_IRQ_CFG))
                    prdata_reg[7:0] <= irq_cfg_reg;
                else if (index_hit(paddr, `CSIW_IDX_WIN_EN))
                    prdata_reg[7:0] <= win_en_reg;
                else if (index_hit(paddr, `CSIW_IDX_STATUS))
                    prdata_reg[7:0] <= status_view;
                else if (index_hit(paddr, `CSIW_IDX_GEN_CTL))
                    prdata_reg[7:0] <= gen_ctl_reg;
                else if (index_hit(paddr, `CSIW_IDX_ACK_MODE))
                    prdata_reg[7:0] <= ack_mode_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            irq_cfg_reg <= `CSIW_RST_IRQ_CFG;
        else if (irq_cfg_wr)
            irq_cfg_reg <= pwdata[7:0] & `CSIW_IRQ_CFG_MASK;
    end

    // Independent bits, one per window
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            win_en_reg <= `CSIW_RST_WIN_EN;
        else if (win_en_wr)
            win_en_reg <= pwdata[7:0] & `CSIW_WIN_EN_MASK;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            gen_ctl_reg  <= `CSIW_RST_GEN_CTL;
            ack_mode_reg <= `CSIW_RST_ACK_MODE;
        end
        else if (wr_done)
        begin
            if (index_hit(paddr, `CSIW_IDX_GEN_CTL))
                gen_ctl_reg <= {7'h00, pwdata[`CSIW_BIT_RING_EN]};
            if (index_hit(paddr, `CSIW_IDX_ACK_MODE))
                ack_mode_reg <= {7'h00, pwdata[`CSIW_BIT_EXPL_ACK]};
        end
    end

    // Card pins: two stages, then a third for edge detection
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= 4'hf;
            sync2_reg <= 4'hf;
            prev_reg  <= 4'hf;
        end
        else
        begin
            sync1_reg <= {card_detect_a_n, card_detect_b_n,
                          card_busy_n, card_status_change_n};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign detect_event  = (sync2_reg[3] != prev_reg[3])
                        || (sync2_reg[2] != prev_reg[2]);
    // Busy released means the card is ready again
    assign ready_event   = sync2_reg[1] && !prev_reg[1];
    // With ring indicate on, the input carries ring, not status
    assign battery_event = (sync2_reg[0] != prev_reg[0])
                        && !ring_indicate_en;

    function automatic logic flag_next(input logic flag,
                                       input logic en,
                                       input logic ev,
                                       input logic clr);
        if (!en)
            return 1'b0;
        if (ev)
            return 1'b1;
        if (clr)
            return 1'b0;
        return flag;
    endfunction

    // Event beats clear; a read clears only what it returned
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            detect_change_flag_reg <= 1'b0;
            ready_change_flag_reg  <= 1'b0;
            battery_flag_reg       <= 1'b0;
        end
        else
        begin
            detect_change_flag_reg <= flag_next(detect_change_flag_reg,
                card_detect_irq_en, detect_event,
                explicit_writeback_ack
                    ? status_wr && pwdata[`CSIW_BIT_DETECT]
                    : status_rd && prdata_reg[`CSIW_BIT_DETECT]);
            ready_change_flag_reg <= flag_next(ready_change_flag_reg,
                ready_irq_en, ready_event,
                explicit_writeback_ack
                    ? status_wr && pwdata[`CSIW_BIT_READY]
                    : status_rd && prdata_reg[`CSIW_BIT_READY]);
            battery_flag_reg <= flag_next(battery_flag_reg,
                battery_status_irq_en, battery_event,
                explicit_writeback_ack
                    ? status_wr && pwdata[`CSIW_BIT_BATTERY]
                    : status_rd && prdata_reg[`CSIW_BIT_BATTERY]);
        end
    end

    // Request holds while any flag stands
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            irq_reg <= 16'h0000;
        else if (detect_change_flag_reg || ready_change_flag_reg
                 || battery_flag_reg)
            irq_reg <= steer_decode(irq_line_steer);
        else
            irq_reg <= 16'h0000;
    end

    assign irq_out = irq_reg;

    // Window decode; one cycle from system address to card pins
    logic [IO_WINDOWS-1:0]  io_hit;
    logic [MEM_WINDOWS-1:0] mem_hit;
    logic [ADDR_W-1:0]      mem_xlat;
    logic                   io_space;

    assign io_space = sys_addr[ADDR_W-1:`CSIW_IO_SPACE_LO] == '0;

    always_comb
    begin
        io_hit = '0;
        for (int i = 0; i < IO_WINDOWS; i++)
            io_hit[i] = sys_valid && sys_is_io && io_space
                     && io_window_en[i]
                     && sys_addr[15:0] >= io_win_start[i]
                     && sys_addr[15:0] <= io_win_stop[i];
    end

    always_comb
    begin
        mem_hit  = '0;
        mem_xlat = '0;
        for (int i = 0; i < MEM_WINDOWS; i++)
        begin
            mem_hit[i] = sys_valid && !sys_is_io
                      && mem_window_en[i]
                      && sys_addr[19:12] >= mem_win_start[i]
                      && sys_addr[19:12] <= mem_win_stop[i];
            // Lowest window wins if software overlaps them
            if (mem_hit[i] && mem_xlat == '0)
                mem_xlat = ADDR_W'({mem_win_offset[i], 12'h000}
                         + {6'h00, sys_addr[19:0]});
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            card_enable_n_reg <= 2'b11;
            card_addr_reg     <= '0;
            io_hit_reg        <= '0;
            mem_hit_reg       <= '0;
        end
        else
        begin
            io_hit_reg  <= io_hit;
            mem_hit_reg <= mem_hit;
            card_enable_n_reg <= (|io_hit || |mem_hit) ? 2'b00 : 2'b11;
            if (|io_hit)
                card_addr_reg <= sys_addr;
            else if (|mem_hit)
                card_addr_reg <= mem_xlat;
        end
    end

    assign card_enable_n  = card_enable_n_reg;
    assign card_addr      = card_addr_reg;
    assign io_window_hit  = io_hit_reg;
    assign mem_window_hit = mem_hit_reg;

endmodule

`default_nettype wire

// ---- tb/csiw_top_asserts.sv ----
// Purpose: Port-level checks for csiw_top
// Assumes: Single clk_sys domain, rst asynchronous active high
// Notes:   Bound to every csiw_top instance
`timescale 1ns/1ps
`default_nettype none
module csiw_top_asserts #(
    parameter int ADDR_W      = 26,
    parameter int IO_WINDOWS  = 2,
    parameter int MEM_WINDOWS = 5
) (
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    input wire logic [15:0]            irq_out,
    input wire logic                   sys_valid,
    input wire logic                   sys_is_io,
    input wire logic [ADDR_W-1:0]      sys_addr,
    input wire logic [1:0]             card_enable_n,
    input wire logic [ADDR_W-1:0]      card_addr,
    input wire logic [IO_WINDOWS-1:0]  io_window_hit,
    input wire logic [MEM_WINDOWS-1:0] mem_window_hit
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_bad_setup;
        psel && !penable
            && !(paddr inside {12'h004, 12'h008, 12'h010, 12'h014, 12'h018});
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_zero_wait: assert property (s_access |-> pready)
        else $error("pready low in access phase");
    a_slverr_bad_addr: assert property (s_bad_setup ##1 s_access
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_cfg_reserved_zero: assert property (s_access and (!pwrite
        && paddr == 12'h014) |-> prdata[1] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("config reserved bit not zero");
    a_win_reserved_zero: assert property (s_access and (!pwrite
        && paddr == 12'h018) |-> prdata[5] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("window reserved bit not zero");
    a_irq_one_line: assert property ($onehot0(irq_out))
        else $error("more than one irq line");
    a_irq_legal_lines: assert property ((irq_out & 16'h2147) == 16'h0)
        else $error("irq on unused line");
    a_io_addr_pass: assert property (|io_window_hit
        |-> card_addr == $past(sys_addr))
        else $error("io address translated");
    a_enable_any_hit: assert property (card_enable_n
        == {2{~(|{io_window_hit, mem_window_hit})}})
        else $error("card enables disagree with hits");
    a_idle_no_hit: assert property (!$past(sys_valid)
        |-> {io_window_hit, mem_window_hit} == '0)
        else $error("hit without access");
    a_io_high_refused: assert property (sys_valid && sys_is_io
        && sys_addr[ADDR_W-1:16] != '0 |=> io_window_hit == '0)
        else $error("io hit above 64k");
endmodule
bind csiw_top csiw_top_asserts #(
    .ADDR_W      (ADDR_W),
    .IO_WINDOWS  (IO_WINDOWS),
    .MEM_WINDOWS (MEM_WINDOWS)
) u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
    .pslverr, .irq_out, .sys_valid, .sys_is_io, .sys_addr, .card_enable_n,
    .card_addr, .io_window_hit, .mem_window_hit);
`default_nettype wire

// ---- tb/csiw_card_model.sv ----
// Purpose: Removable card on the socket
// Assumes: Card pins are active low
// Notes:   Card goes busy after every enabled cycle
`timescale 1ns/1ps
`default_nettype none
module csiw_card_model #(
    parameter int BUSY_CYC = 6
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       present,
    input  wire logic       stschg,
    input  wire logic [1:0] card_enable_n,
    output logic            card_detect_a_n,
    output logic            card_detect_b_n,
    output logic            card_busy_n,
    output logic            card_status_change_n
);
    int busy_cnt;
    // Slow card: ready only returns after BUSY_CYC
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            busy_cnt <= 0;
        else if (card_enable_n != 2'b11)
            busy_cnt <= BUSY_CYC;
        else if (busy_cnt != 0)
            busy_cnt <= busy_cnt - 1;
    end
    assign card_busy_n          = (busy_cnt == 0);
    assign card_detect_a_n      = !present;
    assign card_detect_b_n      = !present;
    assign card_status_change_n = !stschg;
endmodule
`default_nettype wire

// ---- tb/card_irq_and_window_enable_tb.sv ----
// Purpose: Self-checking bench for csiw_top
// Assumes: Zero wait APB, registers at four times their index
// Notes:   Window bounds driven directly by the bench
`timescale 1ns/1ps
`default_nettype none
module card_irq_and_window_enable_tb;
    logic              clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, q;
    logic              present, stschg, sys_valid, sys_is_io, e;
    logic              cd_a_n, cd_b_n, busy_n, stschg_n;
    logic [15:0]       irq_out;
    logic [25:0]       sys_addr, card_addr, a;
    logic [1:0][15:0]  io_start, io_stop;
    logic [4:0][7:0]   m_start, m_stop;
    logic [4:0][13:0]  m_off;
    logic [1:0]        card_enable_n, io_hit;
    logic [4:0]        mem_hit;
    logic [7:0]        en;
    int                num_errors, n_checks, cyc;

    csiw_top DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .card_detect_a_n(cd_a_n), .card_detect_b_n(cd_b_n),
        .card_busy_n(busy_n), .card_status_change_n(stschg_n),
        .irq_out(irq_out), .sys_valid(sys_valid), .sys_is_io(sys_is_io),
        .sys_addr(sys_addr), .io_win_start(io_start), .io_win_stop(io_stop),
        .mem_win_start(m_start), .mem_win_stop(m_stop),
        .mem_win_offset(m_off), .card_enable_n(card_enable_n),
        .card_addr(card_addr), .io_window_hit(io_hit),
        .mem_window_hit(mem_hit));
    csiw_card_model #(.BUSY_CYC(6)) u_card (.clk_sys(clk_sys), .rst(rst),
        .present(present), .stschg(stschg), .card_enable_n(card_enable_n),
        .card_detect_a_n(cd_a_n), .card_detect_b_n(cd_b_n),
        .card_busy_n(busy_n), .card_status_change_n(stschg_n));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic sacc(input logic io, input logic [25:0] ad);
        @(posedge clk_sys);
        sys_valid <= 1'b1;
        sys_is_io <= io;
        sys_addr  <= ad;
        @(posedge clk_sys);
        sys_valid <= 1'b0;
        #1;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_regs();
        apb(0, 12'h014, 0); chk(q, 32'h0);
        apb(0, 12'h018, 0); chk(q, 32'h0);
        apb(1, 12'h014, 32'hff);
        apb(0, 12'h014, 0); chk(q, 32'hfd);
        apb(1, 12'h018, 32'hff);
        apb(0, 12'h018, 0); chk(q, 32'hdf);
        apb(1, 12'h0fc, 32'hff); chk(e, 1'b1);
        apb(1, 12'h014, 0);
        apb(1, 12'h018, 0);
        $display("t_regs done");
    endtask

    task automatic t_steer();
        apb(1, 12'h014, 32'h08);
        present <= 1'b1;
        settle(8);
        for (int c = 0; c < 16; c++)
        begin
            apb(1, 12'h014, {24'h0, c[3:0], 4'h8});
            settle(2);
            chk(irq_out, 16'hdeb8 & (16'h1 << c));
        end
        apb(0, 12'h010, 0); chk(q, 32'h08);
        settle(2); chk(irq_out, 16'h0);
        apb(0, 12'h010, 0); chk(q, 32'h0);
        present <= 1'b0;
        settle(8);
        apb(1, 12'h014, 0);
        apb(0, 12'h010, 0); chk(q, 32'h0);
        present <= 1'b1;
        settle(8);
        apb(1, 12'h014, 32'hf8);
        settle(2); chk(irq_out, 16'h0);
        apb(0, 12'h010, 0); chk(q, 32'h0);
        apb(1, 12'h014, 0);
        $display("t_steer done");
    endtask

    task automatic t_battery();
        apb(1, 12'h008, 1);
        apb(0, 12'h008, 0); chk(q, 32'h01);
        apb(1, 12'h014, 32'hf1);
        stschg <= 1'b1;
        settle(8);
        apb(0, 12'h010, 0); chk(q, 32'h0);
        apb(1, 12'h008, 0);
        apb(1, 12'h004, 1);
        stschg <= 1'b0;
        settle(8);
        apb(0, 12'h010, 0); chk(q, 32'h01);
        apb(0, 12'h010, 0); chk(q, 32'h01);
        chk(irq_out, 16'h8000);
        apb(1, 12'h010, 1);
        settle(2); chk(irq_out, 16'h0);
        apb(0, 12'h010, 0); chk(q, 32'h0);
        apb(1, 12'h014, 0);
        stschg <= 1'b0;
        apb(1, 12'h004, 0);
        $display("t_battery done");
    endtask

    task automatic t_windows();
        for (int i = 0; i < 7; i++)
        begin
            en = (i < 2) ? (8'h40 << i) : (8'h01 << (i - 2));
            a  = (i < 2) ? 26'h180 + 26'h200 * i : {6'h0, m_start[i-2], 12'h234};
            apb(1, 12'h018, {24'h0, en});
            sacc(i < 2, a);
            chk({io_hit, mem_hit}, {en[7:6], en[4:0]});
            chk(card_enable_n, 2'b00);
            chk(card_addr, (i < 2) ? a
                : {6'h0, a[19:0]} + {m_off[i-2], 12'h000});
            apb(1, 12'h018, {24'h0, ~en & 8'hdf});
            sacc(i < 2, a);
            chk({io_hit, mem_hit}, 0);
            chk(card_enable_n, 2'b11);
        end
        apb(1, 12'h018, 32'hc0);
        sacc(1'b1, 26'h10180); chk(io_hit, 2'b00);
        $display("t_windows done");
    endtask

    task automatic t_ready();
        apb(1, 12'h014, 32'h04);
        apb(1, 12'h018, 32'h01);
        sacc(1'b0, {6'h0, m_start[0], 12'h010});
        settle(16);
        apb(0, 12'h010, 0); chk(q, 32'h04);
        apb(1, 12'h014, 0);
        sacc(1'b0, {6'h0, m_start[0], 12'h010});
        settle(16);
        apb(1, 12'h014, 32'h04);
        apb(0, 12'h010, 0); chk(q, 32'h0);
        apb(1, 12'h014, 0);
        $display("t_ready done");
    endtask

    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sys_valid, sys_is_io, sys_addr, stschg, present} = '0;
        // Bounds set before any enable bit goes up
        for (int k = 0; k < 2; k++)
        begin
            io_start[k] = 16'h100 + 16'h200 * k;
            io_stop[k]  = io_start[k] + 16'hff;
        end
        for (int k = 0; k < 5; k++)
        begin
            m_start[k] = 8'h10 * (k + 1);
            m_stop[k]  = m_start[k] + 8'h0f;
            m_off[k]   = 14'h40 * (k + 1);
        end
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_steer();
        t_battery();
        t_windows();
        t_ready();
        finish_test();
    end
endmodule
`default_nettype wire
